// ---- design/ldl_device.sv ----
// Purpose: Serial slave, clock source selection, output pins and trigger of an LED driver
// Assumes: Bus, reference and address pins arrive asynchronous to ref_clk and are synchronised here; the other inputs are not
// Notes:   Contract
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
module ldl_device #(
  parameter int INT_TICK_CYCLES    = ldl_pkg::TB_TICK_CYCLES,
  parameter int DET_TIMEOUT_CYCLES = ldl_pkg::DET_TIMEOUT_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  ldl_if.device           bus,
  input  wire logic [1:0] bus_id_select_pins,
  input  wire logic       slow_ref_clock_input,
  input  wire logic       irq_request,
  input  wire logic       send_trigger,
  input  wire logic       power_save_active,
  output logic            timebase_tick,
  output logic            trigger_received,
  output logic            trigger_busy,
  output logic            internal_osc_stop,
  output logic            general_output_pin,
  output logic            irq_pin_out,
  output logic            irq_pin_drive_n
);
  typedef enum logic [5:0] {
    S_IDLE  = 6'b00_0001,
    S_ADDR  = 6'b00_0010,
    S_REG   = 6'b00_0100,
    S_WDATA = 6'b00_1000,
    S_RDATA = 6'b01_0000,
    S_SKIP  = 6'b10_0000
  } ldl_slave_type;

  ldl_slave_type state;
  logic [5:0]    pin_meta;
  logic [5:0]    pin_sync;
  logic [2:0]    pin_prev;
  logic          scl_s;
  logic          sda_s;
  logic          sync_pulse_pin_s;
  logic          ref_s;
  logic [1:0]    id_s;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_c;
  logic          stop_c;
  logic          ref_rise;
  logic [7:0]    config_reg;
  logic [7:0]    output_reg;
  logic [12:0]   int_cnt;
  logic          int_tick;
  logic [14:0]   det_cnt;
  logic          ext_present;
  logic          use_ext;
  logic          outside_ref_detected;
  logic [1:0]    tx_left;
  logic          tx_pend;
  logic [1:0]    rx_cnt;
  logic          rx_done;
  logic [3:0]    bit_cnt;
  logic [7:0]    rx_sh;
  logic [7:0]    tx_sh;
  logic [7:0]    ptr;
  logic [7:0]    rd_data;
  logic          drv_low;
  logic          master_nack;
  logic          byte_done;
  logic          wr_strobe;

  // Pins pass two flops; only the second stage and its copy feed logic
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      // Idle levels, so no false edge or trigger follows reset
      pin_meta <= 6'h07;
      pin_sync <= 6'h07;
      pin_prev <= 3'h3;
    end
    else
    begin
      pin_meta <= {bus_id_select_pins, slow_ref_clock_input, bus.sync_pulse_pin, bus.sda, bus.scl};
      pin_sync <= pin_meta;
      pin_prev <= {pin_sync[3], pin_sync[1], pin_sync[0]};
    end
  end

  assign scl_s    = pin_sync[0];
  assign sda_s    = pin_sync[1];
  assign sync_pulse_pin_s   = pin_sync[2];
  assign ref_s    = pin_sync[3];
  assign id_s     = pin_sync[5:4];
  assign scl_rise = scl_s & ~pin_prev[0];
  assign scl_fall = ~scl_s & pin_prev[0];
  assign start_c  = scl_s & pin_prev[0] & pin_prev[1] & ~sda_s;
  assign stop_c   = scl_s & pin_prev[0] & ~pin_prev[1] & sda_s;
  assign ref_rise = ref_s & ~pin_prev[2];

  // Internal timebase; halted while power save is active and the present outside reference carries timing
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      int_cnt <= 13'h0000;
    else if (!internal_osc_stop)
      int_cnt <= (int_cnt == 13'(INT_TICK_CYCLES - 1)) ? 13'h0000 : int_cnt + 13'h0001;
  end
  assign int_tick = !internal_osc_stop && (int_cnt == 13'(INT_TICK_CYCLES - 1));

  // A missing edge for one slow period clears presence, so stuck levels read absent
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      det_cnt     <= 15'h0000;
      ext_present <= 1'b0;
    end
    else if (ref_rise)
    begin
      det_cnt     <= 15'h0000;
      ext_present <= 1'b1;
    end
    else if (det_cnt == 15'(DET_TIMEOUT_CYCLES - 1))
      ext_present <= 1'b0;
    else
      det_cnt <= det_cnt + 15'h0001;
  end

  assign use_ext = (config_reg[ldl_pkg::CFG_SRC_LSB +: 2] == ldl_pkg::SRC_EXT) ||
                   ((config_reg[ldl_pkg::CFG_SRC_LSB +: 2] == ldl_pkg::SRC_AUTO) &&
                    ext_present);
  assign outside_ref_detected = ext_present & config_reg[ldl_pkg::CFG_DET_EN_BIT];

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      timebase_tick     <= 1'b0;
      internal_osc_stop <= 1'b0;
    end
    else
    begin
      timebase_tick     <= use_ext ? ref_rise : int_tick;
      internal_osc_stop <= power_save_active & ext_present & use_ext;
    end
  end

  // Trigger out waits for a tick so the low phase spans whole ticks
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_pend <= 1'b0;
      tx_left <= 2'h0;
    end
    else
    begin
      if (send_trigger && tx_left == 2'h0)
        tx_pend <= 1'b1;
      if (timebase_tick && tx_pend)
      begin
        tx_pend <= 1'b0;
        tx_left <= ldl_pkg::SYNC_PULSE_PIN_TX_TICKS;
      end
      else if (timebase_tick && tx_left != 2'h0)
        tx_left <= tx_left - 2'h1;
    end
  end
  assign trigger_busy         = tx_pend | (tx_left != 2'h0);
  assign bus.dev_sync_pulse_pin_out     = 1'b0;
  assign bus.dev_sync_pulse_pin_drive_n = (tx_left == 2'h0);

  // Own trigger is masked; one report per low period
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_cnt           <= 2'h0;
      rx_done          <= 1'b0;
      trigger_received <= 1'b0;
    end
    else
    begin
      trigger_received <= 1'b0;
      if (sync_pulse_pin_s || tx_left != 2'h0)
      begin
        rx_cnt  <= 2'h0;
        rx_done <= 1'b0;
      end
      else if (timebase_tick && !rx_done)
      begin
        // First tick only opens the window; two more span two full periods
        if (rx_cnt == ldl_pkg::SYNC_PULSE_PIN_RX_TICKS)
        begin
          trigger_received <= 1'b1;
          rx_done          <= 1'b1;
        end
        rx_cnt <= rx_cnt + 2'h1;
      end
    end
  end

  always_comb
  begin
    rd_data = 8'h00;
    unique case (ptr)
      ldl_pkg::REG_CONFIG: rd_data = config_reg;
      ldl_pkg::REG_STATUS: rd_data[ldl_pkg::STATUS_EXT_BIT] = outside_ref_detected;
      ldl_pkg::REG_OUTPUT: rd_data = output_reg;
      default:             rd_data = 8'h00;
    endcase
  end

  assign byte_done = scl_fall && (bit_cnt == 4'h8);
  assign wr_strobe = byte_done && (state == S_WDATA);

  // Serial slave; start or stop inside a byte aborts it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state       <= S_IDLE;
      bit_cnt     <= 4'h0;
      rx_sh       <= 8'h00;
      tx_sh       <= 8'h00;
      ptr         <= 8'h00;
      drv_low     <= 1'b0;
      master_nack <= 1'b0;
    end
    else if (start_c)
    begin
      state   <= S_ADDR;
      bit_cnt <= 4'h0;
      drv_low <= 1'b0;
    end
    else if (stop_c)
    begin
      state   <= S_IDLE;
      drv_low <= 1'b0;
    end
    else if (state != S_IDLE && state != S_SKIP && scl_rise)
    begin
      if (bit_cnt < 4'h8)
      begin
        rx_sh   <= {rx_sh[6:0], sda_s};
        tx_sh   <= {tx_sh[6:0], 1'b0};
        bit_cnt <= bit_cnt + 4'h1;
      end
      else
      begin
        bit_cnt <= 4'h9;
        // Own address acknowledge is not a master acknowledge
        if (state == S_RDATA && !drv_low)
        begin
          master_nack <= sda_s;
          if (!sda_s)
            ptr <= ptr + 8'h01;
        end
      end
    end
    else if (state != S_IDLE && state != S_SKIP && scl_fall)
    begin
      if (bit_cnt == 4'h8)
      begin
        unique case (state)
          S_ADDR:
            if (rx_sh[7:1] == ldl_pkg::BUS_ID_BASE + {5'h00, id_s})
            begin
              drv_low     <= 1'b1;
              master_nack <= 1'b0;
              state       <= rx_sh[0] ? S_RDATA : S_REG;
            end
            else
              state <= S_SKIP;
          S_REG:
          begin
            ptr     <= rx_sh;
            drv_low <= 1'b1;
            state   <= S_WDATA;
          end
          S_WDATA:
          begin
            ptr     <= ptr + 8'h01;
            drv_low <= 1'b1;
          end
          S_RDATA: drv_low <= 1'b0;
          default: drv_low <= 1'b0;
        endcase
      end
      else if (bit_cnt == 4'h9)
      begin
        bit_cnt <= 4'h0;
        if (state == S_RDATA && !master_nack)
        begin
          tx_sh   <= rd_data;
          drv_low <= ~rd_data[7];
        end
        else
        begin
          drv_low <= 1'b0;
          if (state == S_RDATA)
            state <= S_SKIP;
        end
      end
      else if (state == S_RDATA)
        drv_low <= ~tx_sh[7];
    end
  end
  assign bus.dev_sda_out     = 1'b0;
  assign bus.dev_sda_drive_n = ~drv_low;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      config_reg <= ldl_pkg::CONFIG_RESET;
      output_reg <= ldl_pkg::OUTPUT_RESET;
    end
    else if (wr_strobe)
    begin
      if (ptr == ldl_pkg::REG_CONFIG)
        config_reg <= rx_sh;
      if (ptr == ldl_pkg::REG_OUTPUT)
        output_reg <= rx_sh;
    end
  end

  // Push-pull in general-purpose mode, open drain as interrupt
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      general_output_pin <= 1'b0;
      irq_pin_out        <= 1'b0;
      irq_pin_drive_n    <= 1'b1;
    end
    else
    begin
      general_output_pin <= output_reg[ldl_pkg::OUT_GPO_BIT];
      if (output_reg[ldl_pkg::OUT_IRQ_SEL_BIT])
      begin
        irq_pin_out     <= output_reg[ldl_pkg::OUT_IRQ_LEVEL_BIT];
        irq_pin_drive_n <= 1'b0;
      end
      else
      begin
        irq_pin_out     <= 1'b0;
        irq_pin_drive_n <= ~irq_request;
      end
    end
  end
endmodule : ldl_device

// ---- design/ldl_pkg.sv ----
// Purpose: Shared constants for the LED driver logic interface and its bus master
// Assumes: ref_clk at 250 MHz on both ends
// Notes:   Timing counts are derived from the figures in their own units
package ldl_pkg;
  localparam int REF_CLK_HZ         = 250_000_000;
  // Nominal slow timebase and the slowest reference still reported present
  localparam int TB_HZ              = 32_768;
  localparam int TB_TICK_CYCLES     = REF_CLK_HZ / TB_HZ;
  localparam int DET_MIN_HZ         = 15_000;
  localparam int DET_TIMEOUT_CYCLES = REF_CLK_HZ / DET_MIN_HZ;
  localparam logic [1:0] SYNC_PULSE_PIN_RX_TICKS = 2'h2;
  localparam logic [1:0] SYNC_PULSE_PIN_TX_TICKS = 2'h3;

  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_OUTPUT = 8'h0E;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] OUTPUT_RESET = 8'h00;
  localparam int CFG_SRC_LSB        = 0;
  localparam int CFG_DET_EN_BIT     = 1;
  localparam logic [1:0] SRC_EXT    = 2'h0;
  localparam logic [1:0] SRC_AUTO   = 2'h2;
  localparam int STATUS_EXT_BIT     = 0;
  localparam int OUT_IRQ_LEVEL_BIT  = 0;
  localparam int OUT_GPO_BIT        = 1;
  localparam int OUT_IRQ_SEL_BIT    = 2;
  localparam logic [6:0] BUS_ID_BASE = 7'h32;

  // Bus master register map, byte addresses
  localparam logic [3:0] HOST_CMD_OFS  = 4'h0;
  localparam logic [3:0] HOST_STAT_OFS = 4'h4;
  localparam int CMD_DEV_LSB        = 0;
  localparam int CMD_RD_BIT         = 7;
  localparam int CMD_REG_LSB        = 8;
  localparam int CMD_DATA_LSB       = 16;
  localparam int CMD_SYNC_PULSE_PIN_BIT       = 24;
  localparam int STAT_BUSY_BIT      = 0;
  localparam int STAT_NACK_BIT      = 1;
  localparam int STAT_SYNC_PULSE_PIN_BIT      = 2;
  localparam int STAT_RDATA_LSB     = 8;
  localparam int HOST_SCL_HZ        = 400_000;
  localparam int HOST_QTR_CYCLES    = REF_CLK_HZ / (4 * HOST_SCL_HZ);
  // Three and a half ticks, so a receiver sees three ticks while the line is low
  localparam int HOST_SYNC_PULSE_PIN_CYCLES   = 3 * TB_TICK_CYCLES + TB_TICK_CYCLES / 2;
endpackage : ldl_pkg

// ---- design/ldl_if.sv ----
// Purpose: Wires between the LED driver device and the host bus master
// Assumes: Pull-ups on the data and trigger lines
// Notes:   Open-drain lines resolve as wired AND; drive_n low means driving
`timescale 1ns/1ps
interface ldl_if;
  logic scl;
  logic sda;
  logic sync_pulse_pin;
  logic dev_sda_out;
  logic dev_sda_drive_n;
  logic host_sda_out;
  logic host_sda_drive_n;
  logic dev_sync_pulse_pin_out;
  logic dev_sync_pulse_pin_drive_n;
  logic host_sync_pulse_pin_out;
  logic host_sync_pulse_pin_drive_n;

  assign sda  = (dev_sda_drive_n | dev_sda_out) & (host_sda_drive_n | host_sda_out);
  assign sync_pulse_pin = (dev_sync_pulse_pin_drive_n | dev_sync_pulse_pin_out) & (host_sync_pulse_pin_drive_n | host_sync_pulse_pin_out);

  modport device (
    input  scl,
    input  sda,
    input  sync_pulse_pin,
    output dev_sda_out,
    output dev_sda_drive_n,
    output dev_sync_pulse_pin_out,
    output dev_sync_pulse_pin_drive_n
  );
  modport host (
    output scl,
    input  sda,
    input  sync_pulse_pin,
    output host_sda_out,
    output host_sda_drive_n,
    output host_sync_pulse_pin_out,
    output host_sync_pulse_pin_drive_n
  );
endinterface : ldl_if

// ---- design/ldl_host.sv ----
// Purpose: Serial bus master driven by software over Avalon-MM
// Assumes: One register transaction per command; ref_clk at 250 MHz
// Notes:   Transfer commands written while busy are dropped; trigger commands only while a trigger runs
`timescale 1ns/1ps
module ldl_host #(
  parameter int QTR_CYCLES  = ldl_pkg::HOST_QTR_CYCLES,
  parameter int SYNC_PULSE_PIN_CYCLES = ldl_pkg::HOST_SYNC_PULSE_PIN_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  ldl_if.host              bus,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_START = 4'b0010,
    H_BIT   = 4'b0100,
    H_STOP  = 4'b1000
  } ldl_host_type;

  ldl_host_type state;
  logic         ack_q;
  logic         req;
  logic         launch;
  logic [6:0]   dev_id;
  logic         rd_mode;
  logic [7:0]   reg_addr;
  logic [7:0]   wr_data;
  logic [7:0]   rx_byte;
  logic [7:0]   rd_result;
  logic [7:0]   cur_byte;
  logic         nack_err;
  logic         ack_hi;
  logic [15:0]  qcnt;
  logic         qtick;
  logic [1:0]   phase;
  logic [2:0]   step;
  logic [3:0]   bit_idx;
  logic [2:0]   bit_sel;
  logic         scl_q;
  logic         sda_rel;
  logic [1:0]   sda_meta;
  logic [15:0]  sync_pulse_pin_cnt;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign launch          = avs_write && ack_q && avs_address == ldl_pkg::HOST_CMD_OFS;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (avs_read && !ack_q)
      begin
        avs_readdata <= 32'h0000_0000;
        if (avs_address == ldl_pkg::HOST_STAT_OFS)
        begin
          avs_readdata[ldl_pkg::STAT_BUSY_BIT]       <= (state != H_IDLE);
          avs_readdata[ldl_pkg::STAT_NACK_BIT]       <= nack_err;
          avs_readdata[ldl_pkg::STAT_SYNC_PULSE_PIN_BIT]       <= (sync_pulse_pin_cnt != 16'h0000);
          avs_readdata[ldl_pkg::STAT_RDATA_LSB +: 8] <= rd_result;
        end
      end
    end
  end

  // Sender holds the trigger line long enough for three receiver ticks
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sync_pulse_pin_cnt <= 16'h0000;
    else if (launch && avs_writedata[ldl_pkg::CMD_SYNC_PULSE_PIN_BIT] && sync_pulse_pin_cnt == 16'h0000)
      sync_pulse_pin_cnt <= 16'(SYNC_PULSE_PIN_CYCLES);
    else if (sync_pulse_pin_cnt != 16'h0000)
      sync_pulse_pin_cnt <= sync_pulse_pin_cnt - 16'h0001;
  end
  assign bus.host_sync_pulse_pin_out     = 1'b0;
  assign bus.host_sync_pulse_pin_drive_n = (sync_pulse_pin_cnt == 16'h0000);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sda_meta <= 2'h3;
    else
      sda_meta <= {sda_meta[0], bus.sda};
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      qcnt <= 16'h0000;
    else if (state == H_IDLE || qtick)
      qcnt <= 16'h0000;
    else
      qcnt <= qcnt + 16'h0001;
  end
  assign qtick = (state != H_IDLE) && (qcnt == 16'(QTR_CYCLES - 1));

  always_comb
  begin
    unique case (step)
      3'h0:    cur_byte = {dev_id, 1'b0};
      3'h1:    cur_byte = reg_addr;
      3'h2:    cur_byte = wr_data;
      3'h3:    cur_byte = {dev_id, 1'b1};
      default: cur_byte = 8'hFF;
    endcase
  end
  assign bit_sel = 3'h7 - bit_idx[2:0];

  // Data changes only with clock low; start and stop edges with clock high
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state     <= H_IDLE;
      phase     <= 2'h0;
      step      <= 3'h0;
      bit_idx   <= 4'h0;
      scl_q     <= 1'b1;
      sda_rel   <= 1'b1;
      dev_id    <= 7'h00;
      rd_mode   <= 1'b0;
      reg_addr  <= 8'h00;
      wr_data   <= 8'h00;
      rx_byte   <= 8'h00;
      rd_result <= 8'h00;
      nack_err  <= 1'b0;
      ack_hi    <= 1'b0;
    end
    else if (state == H_IDLE)
    begin
      if (launch && !avs_writedata[ldl_pkg::CMD_SYNC_PULSE_PIN_BIT])
      begin
        dev_id   <= avs_writedata[ldl_pkg::CMD_DEV_LSB +: 7];
        rd_mode  <= avs_writedata[ldl_pkg::CMD_RD_BIT];
        reg_addr <= avs_writedata[ldl_pkg::CMD_REG_LSB +: 8];
        wr_data  <= avs_writedata[ldl_pkg::CMD_DATA_LSB +: 8];
        nack_err <= 1'b0;
        step     <= 3'h0;
        phase    <= 2'h0;
        state    <= H_START;
      end
    end
    else if (qtick)
    begin
      phase <= phase + 2'h1;
      unique case (state)
        H_START:
          unique case (phase)
            2'h0: sda_rel <= 1'b1;
            2'h1: scl_q   <= 1'b1;
            2'h2: sda_rel <= 1'b0;
            default:
            begin
              scl_q   <= 1'b0;
              bit_idx <= 4'h0;
              state   <= H_BIT;
            end
          endcase
        H_BIT:
          unique case (phase)
            2'h0: sda_rel <= (bit_idx == 4'h8 || step == 3'h4) ? 1'b1 : cur_byte[bit_sel];
            2'h1: scl_q   <= 1'b1;
            2'h2:
              if (bit_idx != 4'h8)
                rx_byte <= {rx_byte[6:0], sda_meta[1]};
              else
                ack_hi <= sda_meta[1];
            default:
            begin
              scl_q <= 1'b0;
              if (bit_idx != 4'h8)
                bit_idx <= bit_idx + 4'h1;
              else if (step != 3'h4 && ack_hi)
              begin
                nack_err <= 1'b1;
                state    <= H_STOP;
              end
              else
              begin
                bit_idx <= 4'h0;
                unique case (step)
                  3'h0: step <= 3'h1;
                  3'h1:
                    if (rd_mode)
                    begin
                      step  <= 3'h3;
                      state <= H_START;
                    end
                    else
                      step <= 3'h2;
                  3'h3: step <= 3'h4;
                  default:
                  begin
                    if (step == 3'h4)
                      rd_result <= rx_byte;
                    state <= H_STOP;
                  end
                endcase
              end
            end
          endcase
        H_STOP:
          unique case (phase)
            2'h0: sda_rel <= 1'b0;
            2'h1: scl_q   <= 1'b1;
            2'h2: sda_rel <= 1'b1;
            default: state <= H_IDLE;
          endcase
        default: state <= H_IDLE;
      endcase
    end
  end

  assign bus.scl              = scl_q;
  assign bus.host_sda_out     = 1'b0;
  assign bus.host_sda_drive_n = sda_rel;
endmodule : ldl_host

// ---- tb/ldl_chk.sv ----
// Purpose: Checks on the serial and trigger lines between both ends
// Assumes: One ref_clk domain, rst active high
// Notes:   Counters keep long spans out of the properties
`timescale 1ns/1ps
module ldl_chk #(
  parameter int TICK = 20,
  parameter int QTR  = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sync_pulse_pin,
  input wire logic dev_sda_out,
  input wire logic dev_sda_drive_n,
  input wire logic dev_sync_pulse_pin_out,
  input wire logic dev_sync_pulse_pin_drive_n,
  input wire logic trigger_received
);
  logic [15:0] dev_low;
  logic [15:0] line_low;
  logic [15:0] ack_low;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      dev_low <= '0;
    else
      dev_low <= dev_sync_pulse_pin_drive_n ? 16'h0000 : dev_low + 16'h0001;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      line_low <= '0;
    else
      line_low <= sync_pulse_pin ? 16'h0000 : line_low + 16'h0001;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      ack_low <= '0;
    else
      ack_low <= dev_sda_drive_n ? 16'h0000 : ack_low + 16'h0001;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  open_drain_a: assert property (!dev_sda_out && !dev_sync_pulse_pin_out)
    else $error("device drives a line high");
  sda_take_a: assert property ($fell(dev_sda_drive_n) |-> !scl)
    else $error("device pulls data while clock high");
  sda_free_a: assert property ($rose(dev_sda_drive_n) |-> !scl)
    else $error("device releases data while clock high");
  no_start_a: assert property ($fell(sda) && scl && $past(scl) |-> dev_sda_drive_n)
    else $error("device made a start");
  sync_pulse_pin_width_a: assert property ($rose(dev_sync_pulse_pin_drive_n) |-> dev_low == 3 * TICK)
    else $error("sent trigger width wrong");
  rx_min_a: assert property (trigger_received |-> line_low >= 2 * TICK)
    else $error("trigger taken too early");
  own_mask_a: assert property (trigger_received |-> dev_sync_pulse_pin_drive_n && !sync_pulse_pin)
    else $error("own trigger taken");
  sda_bound_a: assert property (ack_low < 40 * QTR)
    else $error("device holds data too long");

  cover property ($rose(dev_sync_pulse_pin_drive_n));
  cover property (trigger_received);
  cover property ($fell(dev_sda_drive_n) ##1 !dev_sda_drive_n);
endmodule : ldl_chk

// ---- tb/testbench.sv ----
// Purpose: Both ends joined, driven over Avalon and the device pins
// Assumes: Address pins at 01, small tick and timeout counts
// Notes:   Host offers one register per command, so no burst is tried
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t got %h", $time, g); end end
module testbench;
  localparam int TICK = 20;
  localparam int QTR  = 8;
  localparam logic [6:0] ID = 7'h33;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        slow_ref_clock_input = 1'b0;
  logic        ext_run = 1'b1;
  logic [2:0]  div = 3'h0;
  logic        irq_request = 1'b0;
  logic        send_trigger = 1'b0;
  logic        power_save_active = 1'b0;
  logic        timebase_tick;
  logic        trigger_busy;
  logic        internal_osc_stop;
  int          tick_count = 0;
  int          t0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        trigger_received;
  logic        general_output_pin;
  logic        irq_pin_out;
  logic        irq_pin_drive_n;
  logic [31:0] st;
  int          fail_count = 0;
  int          n_tests = 0;
  int          rx_count = 0;

  ldl_if bus ();
  ldl_device #(.INT_TICK_CYCLES(TICK), .DET_TIMEOUT_CYCLES(60)) i_ldl_device (
    .ref_clk, .rst, .bus(bus), .bus_id_select_pins(2'h1), .slow_ref_clock_input,
    .irq_request, .send_trigger, .power_save_active, .timebase_tick,
    .trigger_received, .trigger_busy, .internal_osc_stop, .general_output_pin,
    .irq_pin_out, .irq_pin_drive_n);
  ldl_host #(.QTR_CYCLES(QTR), .SYNC_PULSE_PIN_CYCLES(3 * TICK + TICK / 2)) i_ldl_host (
    .ref_clk, .rst, .bus(bus), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest);
  ldl_chk #(.TICK(TICK), .QTR(QTR)) i_ldl_chk (
    .ref_clk, .rst, .scl(bus.scl), .sda(bus.sda), .sync_pulse_pin(bus.sync_pulse_pin),
    .dev_sda_out(bus.dev_sda_out), .dev_sda_drive_n(bus.dev_sda_drive_n),
    .dev_sync_pulse_pin_out(bus.dev_sync_pulse_pin_out), .dev_sync_pulse_pin_drive_n(bus.dev_sync_pulse_pin_drive_n),
    .trigger_received);

  always #2 ref_clk = ~ref_clk;
  // Reference at 64 ns, far above nominal, must still count as present
  always @(posedge ref_clk)
  begin
    div <= div + 3'h1;
    if (div == 3'h7 && ext_run)
      slow_ref_clock_input <= ~slow_ref_clock_input;
    if (trigger_received === 1'b1)
      rx_count++;
    if (timebase_tick === 1'b1)
      tick_count <= tick_count + 1;
  end

  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge ref_clk);
    st = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : avs

  // Busy and trigger flags are polled, so a dead link ends at the watchdog
  task automatic op(input logic [6:0] id, input logic rd, input logic [7:0] r,
                    input logic [7:0] d, input logic trg);
    avs(1'b1, ldl_pkg::HOST_CMD_OFS, {7'h00, trg, d, r, rd, id});
    st = 32'h0000_0001;
    while (st[0] !== 1'b0 || st[2] !== 1'b0)
      avs(1'b0, ldl_pkg::HOST_STAT_OFS, 32'h0000_0000);
  endtask : op

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    op(ID, 1'b0, 8'h0E, 8'h07, 1'b0);
    `CHK(st[1], 1'b0)
    `CHK({irq_pin_out, irq_pin_drive_n, general_output_pin}, 3'b101)
    op(ID, 1'b1, 8'h0E, 8'h00, 1'b0);
    `CHK(st[15:8], 8'h07)
    irq_request <= 1'b1;
    op(ID, 1'b0, 8'h0E, 8'h02, 1'b0);
    `CHK({irq_pin_out, irq_pin_drive_n, general_output_pin}, 3'b001)
    irq_request <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(irq_pin_drive_n, 1'b1)
    op(7'h35, 1'b0, 8'h0E, 8'h00, 1'b0);
    `CHK(st[1], 1'b1)
    op(ID, 1'b0, 8'h08, 8'h02, 1'b0);
    op(ID, 1'b1, 8'h0C, 8'h00, 1'b0);
    `CHK(st[8], 1'b1)
    t0 = tick_count;
    repeat (160) @(posedge ref_clk);
    `CHK(tick_count - t0, 10)
    power_save_active <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK(internal_osc_stop, 1'b1)
    ext_run <= 1'b0;
    repeat (100) @(posedge ref_clk);
    op(ID, 1'b1, 8'h0C, 8'h00, 1'b0);
    `CHK(st[8], 1'b0)
    `CHK(internal_osc_stop, 1'b0)
    ext_run <= 1'b1;
    op(ID, 1'b0, 8'h08, 8'h01, 1'b0);
    t0 = tick_count;
    repeat (160) @(posedge ref_clk);
    `CHK(tick_count - t0, 160 / TICK)
    `CHK(internal_osc_stop, 1'b0)
    send_trigger <= 1'b1;
    @(posedge ref_clk);
    send_trigger <= 1'b0;
    @(posedge ref_clk);
    `CHK(trigger_busy, 1'b1)
    repeat (5 * TICK) @(posedge ref_clk);
    `CHK(rx_count, 0)
    `CHK(trigger_busy, 1'b0)
    op(ID, 1'b0, 8'h00, 8'h00, 1'b1);
    repeat (2 * TICK) @(posedge ref_clk);
    `CHK(rx_count, 1)
    end_of_test();
  end
endmodule : testbench
